// ==== rtl/uec_pkg.sv ====
// constants and carrier types for the endpoint 0 control and status block
package uec_pkg;
	// register byte offsets
	localparam logic [7:0] CSR_OFS = 8'h00;
	localparam logic [7:0] CFG_OFS = 8'h04;
	localparam logic [7:0] IST_OFS = 8'h08;
	localparam logic [7:0] IMSK_OFS = 8'h0C;
	localparam logic [7:0] STATE_OFS = 8'h10;
	// decoded register selects
	localparam logic [2:0] SEL_CSR = 3'h0;
	localparam logic [2:0] SEL_CFG = 3'h1;
	localparam logic [2:0] SEL_IST = 3'h2;
	localparam logic [2:0] SEL_IMSK = 3'h3;
	localparam logic [2:0] SEL_STATE = 3'h4;
	localparam logic [2:0] SEL_NONE = 3'h7;
	// endpoint 0 register bit positions
	localparam int B_PING = 27;
	localparam int B_UNLOCK = 26;
	localparam int B_TOGGLE = 25;
	localparam int B_FLUSH = 24;
	localparam int B_REQ23 = 23;
	localparam int B_REQ22 = 22;
	localparam int B_INREQ = 21;
	localparam int B_SETEND = 20;
	localparam int B_TXRDY = 17;
	localparam int B_RXRDY = 16;
	// configuration register fields
	localparam int B_HOST = 0;
	localparam int B_SPD = 1;
	localparam int B_NAK_LIMIT_TIME = 4;
	localparam logic [1:0] SPD_HIGH = 2'h2;
	// interrupt status bits
	localparam int IRQ_W = 5;
	localparam int IRQ_SETEND = 0;
	localparam int IRQ_RXRDY = 1;
	localparam int IRQ_DONE = 2;
	localparam int IRQ_HALT = 3;
	localparam int IRQ_BUS = 4;
	// fixed resources, shown in the state register
	localparam logic [3:0] NUM_TX_EP = 4'h7;
	localparam logic [3:0] NUM_RX_EP = 4'h7;
	localparam logic [3:0] NUM_DMA_CH = 4'h8;
	// flags: fifo ram is internal and sized at run time
	localparam logic [31:0] CAP_VALUE = {8'h00, 4'hF, NUM_DMA_CH,
		NUM_RX_EP, NUM_TX_EP, 3'h7, 5'h00};
	// nak limit counts in microframe ticks
	localparam int NAK_TICK_NS = 125000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_CYCLES = NAK_TICK_NS / CLK_PERIOD_NS;
	localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

	// pulses from the packet engine
	typedef struct packed {
		logic rx_packet;
		logic setup_end;
		logic txn_done;
		logic nak;
		logic toggle_adv;
		logic bus_event;
	} uec_link_in_type;

	// commands and levels to the packet engine
	typedef struct packed {
		logic txn_start;
		logic txn_status;
		logic txn_in;
		logic ping_enable;
		logic fifo_flush;
		logic ep0_halted;
		logic host_mode;
		logic [1:0] speed;
	} uec_link_out_type;
endpackage

// ==== rtl/uec_nak_timer.sv ====
// nak limit timer for endpoint 0
`timescale 1ns/1ps
`default_nettype none
module uec_nak_timer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic nak,
	input wire logic clear,
	input wire logic [4:0] limit,
	output logic expired
);
	typedef struct packed {
		logic active;
		logic [11:0] tick_cnt;
		logic [5:0] ticks;
		logic expired;
	} uec_nak_state_type;

	uec_nak_state_type st_reg, st_next;

	////////////////////////////////////////////////////////////////////
	// count ticks from the first nak until some other answer
	always_comb begin
		st_next = st_reg;
		st_next.expired = 1'b0;
		if (clear || !enable) begin
			st_next = '0;
		end else begin
			if (nak) begin
				st_next.active = 1'b1;
			end
			if (st_reg.active) begin
				st_next.tick_cnt = st_reg.tick_cnt + 12'h001;
				if (st_reg.tick_cnt == uec_pkg::TICK_LAST) begin
					st_next.tick_cnt = 12'h000;
					st_next.ticks = st_reg.ticks + 6'h01;
				end
				// strictly longer than the limit, then one shot
				if (st_reg.ticks > {1'b0, limit}) begin
					st_next = '0;
					st_next.expired = 1'b1;
				end
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign expired = st_reg.expired;
endmodule
`default_nettype wire

// ==== rtl/uec_irq.sv ====
// sticky interrupt status with mask and one level output
`timescale 1ns/1ps
`default_nettype none
module uec_irq (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] events,
	input wire logic [4:0] w1c,
	input wire logic mask_we,
	input wire logic [4:0] mask_wdata,
	output logic [4:0] status,
	output logic [4:0] mask,
	output logic irq
);
	typedef struct packed {
		logic [4:0] status;
		logic [4:0] mask;
		logic irq;
	} uec_irq_state_type;

	uec_irq_state_type st_reg, st_next;

	////////////////////////////////////////////////////////////////////
	// event set wins over a write-one clear in the same cycle
	always_comb begin
		st_next = st_reg;
		st_next.status = (st_reg.status & ~w1c) | events;
		if (mask_we) begin
			st_next.mask = mask_wdata;
		end
		st_next.irq = |(st_next.status & st_next.mask);
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign status = st_reg.status;
	assign mask = st_reg.mask;
	assign irq = st_reg.irq;
endmodule
`default_nettype wire

// ==== rtl/uec_ep0_ctrl.sv ====
// endpoint 0 control and status block with its register slave
`timescale 1ns/1ps
`default_nettype none
module uec_ep0_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire uec_pkg::uec_link_in_type link_in,
	output uec_pkg::uec_link_out_type link_out,
	output logic irq
);
	typedef struct packed {
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic bslverr;
		logic rvalid;
		logic rslverr;
		logic r_csr;
		logic [31:0] rdata;
		logic host_mode;
		logic [1:0] speed;
		logic [4:0] nak_limit_time;
		logic ping_suppress;
		logic toggle_write_unlock;
		logic ep0_toggle_state;
		logic ep0_fifo_flush;
		logic clear_setup_end_req;
		logic nak_limit_halt;
		logic clear_rx_ready_req;
		logic status_stage_req;
		logic in_request;
		logic setup_end_flag;
		logic tx_packet_ready;
		logic rx_packet_ready;
		logic txn_busy;
		logic txn_start;
		logic txn_status;
		logic txn_in;
		logic halted;
	} uec_main_state_type;

	uec_main_state_type st_reg, st_next;
	logic wr_go;
	logic csr_wr;
	logic tog_wr;
	logic start;
	logic stat_start;
	logic [2:0] wsel;
	logic [31:0] wm;
	logic [31:0] wb;
	logic [31:0] csr_v;
	logic [31:0] rd_v;
	logic nak_expired;
	logic [4:0] ist_w1c;
	logic imsk_we;
	logic [4:0] ist;
	logic [4:0] imsk;
	logic [4:0] events;

	// address decode shared by the read and write paths
	function automatic logic [2:0] reg_sel(input logic [7:0] a);
		logic [2:0] s;
		s = uec_pkg::SEL_NONE;
		unique case (a)
			uec_pkg::CSR_OFS: s = uec_pkg::SEL_CSR;
			uec_pkg::CFG_OFS: s = uec_pkg::SEL_CFG;
			uec_pkg::IST_OFS: s = uec_pkg::SEL_IST;
			uec_pkg::IMSK_OFS: s = uec_pkg::SEL_IMSK;
			uec_pkg::STATE_OFS: s = uec_pkg::SEL_STATE;
			default: s = uec_pkg::SEL_NONE;
		endcase
		return s;
	endfunction

	////////////////////////////////////////////////////////////////////
	// register view; role decides what dual bits mean
	always_comb begin
		csr_v = 32'h0000_0000;
		csr_v[uec_pkg::B_PING] = st_reg.ping_suppress;
		csr_v[uec_pkg::B_UNLOCK] = st_reg.toggle_write_unlock;
		csr_v[uec_pkg::B_TOGGLE] = st_reg.ep0_toggle_state;
		csr_v[uec_pkg::B_FLUSH] = st_reg.ep0_fifo_flush;
		csr_v[uec_pkg::B_REQ23] = st_reg.host_mode ?
			st_reg.nak_limit_halt : st_reg.clear_setup_end_req;
		csr_v[uec_pkg::B_REQ22] = st_reg.host_mode ?
			st_reg.status_stage_req : st_reg.clear_rx_ready_req;
		csr_v[uec_pkg::B_INREQ] = st_reg.host_mode & st_reg.in_request;
		csr_v[uec_pkg::B_SETEND] = ~st_reg.host_mode & st_reg.setup_end_flag;
		csr_v[uec_pkg::B_TXRDY] = st_reg.tx_packet_ready;
		csr_v[uec_pkg::B_RXRDY] = st_reg.rx_packet_ready;
		unique case (reg_sel(s_axi_araddr))
			uec_pkg::SEL_CSR: rd_v = csr_v;
			uec_pkg::SEL_CFG: rd_v = {23'h000000, st_reg.nak_limit_time,
				1'b0, st_reg.speed, st_reg.host_mode};
			uec_pkg::SEL_IST: rd_v = {27'h0000000, ist};
			uec_pkg::SEL_IMSK: rd_v = {27'h0000000, imsk};
			// fixed resources and live transaction state
			uec_pkg::SEL_STATE: rd_v = uec_pkg::CAP_VALUE |
				{30'h00000000, st_reg.halted, st_reg.txn_busy};
			default: rd_v = 32'h0000_0000;
		endcase
	end

	// write decode, lanes enabled by byte strobes
	always_comb begin
		wr_go = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
		wsel = reg_sel(st_reg.aw_addr);
		wm = {{8{st_reg.w_strb[3]}}, {8{st_reg.w_strb[2]}},
			{8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};
		wb = st_reg.w_data & wm;
		csr_wr = wr_go && (wsel == uec_pkg::SEL_CSR);
		// toggle takes a value only while unlocked or with the unlock bit in the same write
		tog_wr = csr_wr && st_reg.host_mode && wm[uec_pkg::B_TOGGLE] &&
			(st_reg.toggle_write_unlock || wb[uec_pkg::B_UNLOCK]);
		start = csr_wr && (wb[uec_pkg::B_TXRDY] ||
			(st_reg.host_mode && wb[uec_pkg::B_INREQ]));
		stat_start = start && st_reg.host_mode && wb[uec_pkg::B_REQ22];
		ist_w1c = (wr_go && wsel == uec_pkg::SEL_IST) ?
			wb[4:0] : 5'h00;
		imsk_we = wr_go && (wsel == uec_pkg::SEL_IMSK) && st_reg.w_strb[0];
		events = '0;
		events[uec_pkg::IRQ_SETEND] = link_in.setup_end & ~st_reg.host_mode;
		events[uec_pkg::IRQ_RXRDY] = link_in.rx_packet;
		events[uec_pkg::IRQ_DONE] = link_in.txn_done;
		events[uec_pkg::IRQ_HALT] = nak_expired;
		events[uec_pkg::IRQ_BUS] = link_in.bus_event;
	end

	////////////////////////////////////////////////////////////////////
	// next state: clears and the halt first, then software sets, engine flag sets last
	always_comb begin
		st_next = st_reg;
		st_next.txn_start = 1'b0;
		// unlock, flush and the two clear requests live for one cycle, then drop by themselves
		st_next.toggle_write_unlock = 1'b0;
		st_next.clear_setup_end_req = 1'b0;
		st_next.clear_rx_ready_req = 1'b0;
		st_next.ep0_fifo_flush = 1'b0;

		// bus handshakes
		if (s_axi_awvalid && !st_reg.aw_full) begin
			st_next.aw_full = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.w_full) begin
			st_next.w_full = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (wr_go) begin
			st_next.aw_full = 1'b0;
			st_next.w_full = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bslverr = (wsel == uec_pkg::SEL_NONE) ||
				(wsel == uec_pkg::SEL_STATE);
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st_reg.rvalid) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd_v;
			st_next.rslverr = reg_sel(s_axi_araddr) == uec_pkg::SEL_NONE;
			st_next.r_csr = reg_sel(s_axi_araddr) == uec_pkg::SEL_CSR;
		end

		// clears owed to last cycle's requests and engine reports
		if (st_reg.clear_setup_end_req) begin
			st_next.setup_end_flag = 1'b0;
		end
		if (st_reg.clear_rx_ready_req) begin
			st_next.rx_packet_ready = 1'b0;
		end
		if (st_reg.ep0_fifo_flush) begin
			st_next.tx_packet_ready = 1'b0;
			st_next.rx_packet_ready = 1'b0;
		end
		if (link_in.txn_done || nak_expired) begin
			st_next.tx_packet_ready = 1'b0;
			st_next.in_request = 1'b0;
			st_next.status_stage_req = 1'b0;
			st_next.txn_busy = 1'b0;
		end
		if (nak_expired) begin
			st_next.halted = 1'b1;
		end
		// hardware handshakes advance the toggle
		if (tog_wr) begin
			st_next.ep0_toggle_state = st_reg.w_data[uec_pkg::B_TOGGLE];
		end else if (link_in.toggle_adv) begin
			st_next.ep0_toggle_state = ~st_reg.ep0_toggle_state;
		end

		// configuration; a role swap drops the other role's requests
		if (wr_go && wsel == uec_pkg::SEL_CFG) begin
			if (st_reg.w_strb[0]) begin
				st_next.host_mode = st_reg.w_data[uec_pkg::B_HOST];
				st_next.speed = st_reg.w_data[uec_pkg::B_SPD +: 2];
			end
			if (st_reg.w_strb[0] && st_reg.w_strb[1]) begin
				st_next.nak_limit_time = st_reg.w_data[uec_pkg::B_NAK_LIMIT_TIME +: 5];
			end
			if (st_reg.w_strb[0] &&
				st_reg.w_data[uec_pkg::B_HOST] != st_reg.host_mode) begin
				st_next.nak_limit_halt = 1'b0;
				st_next.status_stage_req = 1'b0;
				st_next.in_request = 1'b0;
				st_next.setup_end_flag = 1'b0;
				st_next.halted = 1'b0;
			end
		end

		// endpoint 0 register writes, decoded per role
		if (csr_wr) begin
			if (wm[uec_pkg::B_PING]) begin
				st_next.ping_suppress = st_reg.w_data[uec_pkg::B_PING];
			end
			if (wb[uec_pkg::B_FLUSH]) begin
				st_next.ep0_fifo_flush = 1'b1;
			end
			if (wb[uec_pkg::B_TXRDY]) begin
				st_next.tx_packet_ready = 1'b1;
			end
			if (st_reg.host_mode) begin
				if (wb[uec_pkg::B_UNLOCK]) begin
					st_next.toggle_write_unlock = 1'b1;
				end
				if (wm[uec_pkg::B_REQ23]) begin
					st_next.nak_limit_halt = st_reg.w_data[uec_pkg::B_REQ23];
				end
				if (wb[uec_pkg::B_REQ22]) begin
					st_next.status_stage_req = 1'b1;
				end
				if (wb[uec_pkg::B_INREQ]) begin
					st_next.in_request = 1'b1;
				end
			end else begin
				if (wb[uec_pkg::B_REQ23]) begin
					st_next.clear_setup_end_req = 1'b1;
				end
				if (wb[uec_pkg::B_REQ22]) begin
					st_next.clear_rx_ready_req = 1'b1;
				end
			end
		end
		// launch: status stage only with tx-ready or IN request
		if (start) begin
			st_next.txn_start = 1'b1;
			st_next.txn_busy = 1'b1;
			st_next.halted = 1'b0;
			st_next.txn_status = stat_start;
			st_next.txn_in = st_reg.host_mode && wb[uec_pkg::B_INREQ];
		end

		// flags raised by the engine win over a same-cycle clear
		if (link_in.setup_end && !st_reg.host_mode) begin
			st_next.setup_end_flag = 1'b1;
		end
		if (link_in.rx_packet) begin
			st_next.rx_packet_ready = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// helpers
	uec_nak_timer u_nak (
		.clk(clk),
		.rst_n(rst_n),
		.enable(st_reg.host_mode && st_reg.nak_limit_halt &&
			st_reg.txn_busy),
		.nak(link_in.nak),
		.clear(link_in.txn_done || st_reg.txn_start),
		.limit(st_reg.nak_limit_time),
		.expired(nak_expired)
	);

	uec_irq u_irq (
		.clk(clk),
		.rst_n(rst_n),
		.events(events),
		.w1c(ist_w1c),
		.mask_we(imsk_we),
		.mask_wdata(st_reg.w_data[4:0]),
		.status(ist),
		.mask(imsk),
		.irq(irq)
	);

	////////////////////////////////////////////////////////////////////
	// outputs; no PING when suppressed in host high speed
	assign s_axi_awready = !st_reg.aw_full;
	assign s_axi_wready = !st_reg.w_full;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bslverr ? 2'h2 : 2'h0;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rslverr ? 2'h2 : 2'h0;
	assign link_out.txn_start = st_reg.txn_start;
	assign link_out.txn_status = st_reg.txn_status;
	assign link_out.txn_in = st_reg.txn_in;
	assign link_out.ping_enable = st_reg.host_mode && !st_reg.ping_suppress &&
		(st_reg.speed == uec_pkg::SPD_HIGH);
	assign link_out.fifo_flush = st_reg.ep0_fifo_flush;
	assign link_out.ep0_halted = st_reg.halted;
	assign link_out.host_mode = st_reg.host_mode;
	assign link_out.speed = st_reg.speed;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	chk_ping_block: assert property (
		csr_wr && wm[uec_pkg::B_PING] && st_reg.w_data[uec_pkg::B_PING] |=>
		!link_out.ping_enable)
		else $error("ping offered while suppressed");
	chk_unlock_drop: assert property (
		st_reg.toggle_write_unlock |=> !st_reg.toggle_write_unlock)
		else $error("toggle unlock did not self-clear");
	chk_toggle_lock: assert property (
		$changed(st_reg.ep0_toggle_state) |->
		$past(tog_wr) || $past(link_in.toggle_adv))
		else $error("toggle changed while locked");
	chk_flush_clear: assert property (
		st_reg.ep0_fifo_flush && !csr_wr |=>
		!st_reg.ep0_fifo_flush && !st_reg.tx_packet_ready)
		else $error("flush did not clear ready");
	chk_setup_end_clr: assert property (
		st_reg.clear_setup_end_req && !link_in.setup_end |=>
		!st_reg.setup_end_flag)
		else $error("setup end flag not cleared");
	chk_nak_halt: assert property (
		nak_expired |=> st_reg.halted && !st_reg.txn_busy)
		else $error("endpoint not halted after nak limit");
	chk_rx_clear: assert property (
		st_reg.clear_rx_ready_req && !link_in.rx_packet |=>
		!st_reg.rx_packet_ready && !st_reg.clear_rx_ready_req)
		else $error("receive ready not cleared");
	chk_status_stage: assert property (
		stat_start |=> link_out.txn_start && link_out.txn_status)
		else $error("status stage not launched");
	chk_upper_zero: assert property (
		st_reg.rvalid && st_reg.r_csr |-> st_reg.rdata[31:28] == 4'h0)
		else $error("unimplemented bits read nonzero");
	chk_role_gate: assert property (
		!st_reg.host_mode && !csr_wr |=> !st_reg.nak_limit_halt)
		else $error("host bit set in device role");

	cov_status_txn: cover property (stat_start ##1 link_out.txn_start);
	cov_flush: cover property (st_reg.ep0_fifo_flush && st_reg.rx_packet_ready);
	cov_nak_halt: cover property (nak_expired ##1 irq);
	cov_dev_setup: cover property (link_in.setup_end ##[1:20]
		st_reg.clear_setup_end_req);
endmodule
`default_nettype wire

// ==== verification/uec_link_model.sv ====
// far-side packet engine model for endpoint 0 transactions
`timescale 1ns/1ps
`default_nettype none
module uec_link_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire uec_pkg::uec_link_out_type link_out,
	input wire logic nak_mode,
	input wire logic [5:0] dly,
	input wire logic [2:0] ev,
	output uec_pkg::uec_link_in_type link_in
);
	logic busy;
	logic stat;
	logic [5:0] cnt;

	////////////////////////////////////////////////////////////////////////
	// one transaction at a time; naks forever unless halted, else done
	// after dly cycles, a delay the bench draws once per run, from 1 to 40
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			stat <= 1'b0;
			cnt <= 6'h00;
			link_in <= '0;
		end else begin
			link_in <= '0;
			link_in.setup_end <= ev[0];
			link_in.rx_packet <= ev[1];
			link_in.bus_event <= ev[2];
			cnt <= cnt + 6'h01;
			if (link_out.txn_start) begin
				busy <= 1'b1;
				stat <= link_out.txn_status;
				cnt <= 6'h00;
			end else if (busy && link_out.ep0_halted) begin
				busy <= 1'b0;
			end else if (busy && nak_mode && cnt[2:0] == 3'h7) begin
				link_in.nak <= 1'b1;
			end else if (busy && !nak_mode && cnt >= dly) begin
				link_in.txn_done <= 1'b1;
				link_in.toggle_adv <= !stat;
				busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the endpoint 0 control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	uec_pkg::uec_link_in_type link_in;
	uec_pkg::uec_link_out_type link_out;
	logic irq;
	logic nak_mode = 1'b0;
	logic [5:0] dly = 6'h04;
	logic [2:0] ev = 3'h0;
	logic last_status = 1'b0;
	logic last_in = 1'b0;
	logic tv;
	logic [65:0] note;
	logic [1:0] exp_b[$];
	logic [65:0] exp_r[$];
	int n_flush = 0;
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;

	always #25 clk = ~clk;

	uec_ep0_ctrl u_uec_ep0_ctrl (.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_in(link_in),
		.link_out(link_out), .irq(irq));

	uec_link_model u_uec_link_model (.clk(clk), .rst_n(rst_n),
		.link_out(link_out), .nak_mode(nak_mode), .dly(dly), .ev(ev),
		.link_in(link_in));

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string nm, input logic [33:0] seen,
		input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// hang guard, well above the longest expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			print_verdict();
		end
	end

	// result watcher: pairs each answer with the oldest note
	always @(posedge clk) begin
		if (bvalid && bready)
			check("bresp", {32'h0, bresp}, {32'h0, exp_b.pop_front()});
		if (rvalid && rready) begin
			note = exp_r.pop_front();
			check("rdata", {rresp, rdata & note[63:32]},
				{note[65:64], note[31:0]});
		end
	end

	// link side capture, start qualifier and flush pulses
	always @(posedge clk) begin
		if (link_out.txn_start) begin
			last_status <= link_out.txn_status;
			last_in <= link_out.txn_in;
		end
		if (link_out.fifo_flush)
			n_flush <= n_flush + 1;
	end

	////////////////////////////////////////////////////////////////////////
	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		exp_b.push_back(er);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask

	// m selects the bits compared, d their expected value
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] d, input logic [1:0] er);
		exp_r.push_back({er, m, d});
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask

	task automatic pulse(input logic [2:0] e);
		@(posedge clk);
		ev <= e;
		@(posedge clk);
		ev <= 3'h0;
		repeat (2) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h4D33));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(uec_pkg::CSR_OFS, 32'hFFFFFFFF, 32'h0, 2'h0);
		rd(uec_pkg::STATE_OFS, 32'hFFFFFFFC, uec_pkg::CAP_VALUE, 2'h0);
		// host, high speed, shortest nak limit
		wr(uec_pkg::CFG_OFS, 32'h00000005, 2'h0);
		repeat (2) @(posedge clk);
		check("ping", 34'(link_out.ping_enable), 34'h1);
		wr(uec_pkg::CSR_OFS, 32'h08000000, 2'h0);
		repeat (2) @(posedge clk);
		check("ping", 34'(link_out.ping_enable), 34'h0);
		// toggle write refused while locked, taken with the unlock
		wr(uec_pkg::CSR_OFS, 32'h02000000, 2'h0);
		rd(uec_pkg::CSR_OFS, 32'h06000000, 32'h0, 2'h0);
		tv = 1'($urandom_range(0, 1));
		wr(uec_pkg::CSR_OFS, {6'h01, tv, 25'h0}, 2'h0);
		rd(uec_pkg::CSR_OFS, 32'h06000000, {6'h0, tv, 25'h0}, 2'h0);
		// status stage against a plain data stage
		dly <= 6'($urandom_range(1, 40));
		wr(uec_pkg::CSR_OFS, 32'h00420000, 2'h0);
		repeat (2) @(posedge clk);
		check("status", 34'(last_status), 34'h1);
		repeat (50) @(posedge clk);
		rd(uec_pkg::CSR_OFS, 32'h00620000, 32'h0, 2'h0);
		rd(uec_pkg::IST_OFS, 32'h4, 32'h4, 2'h0);
		wr(uec_pkg::CSR_OFS, 32'h00020000, 2'h0);
		repeat (50) @(posedge clk);
		check("status", 34'(last_status), 34'h0);
		check("in", 34'(last_in), 34'h0);
		// endless naks: retry without halt enable, halt with it
		nak_mode <= 1'b1;
		wr(uec_pkg::IMSK_OFS, 32'h8, 2'h0);
		wr(uec_pkg::CSR_OFS, 32'h00200000, 2'h0);
		repeat (6000) @(posedge clk);
		check("in", 34'(last_in), 34'h1);
		rd(uec_pkg::STATE_OFS, 32'h2, 32'h0, 2'h0);
		check("irq", 34'(irq), 34'h0);
		wr(uec_pkg::CSR_OFS, 32'h00800000, 2'h0);
		rd(uec_pkg::CSR_OFS, 32'h00800000, 32'h00800000, 2'h0);
		repeat (6000) @(posedge clk);
		rd(uec_pkg::STATE_OFS, 32'h2, 32'h2, 2'h0);
		check("irq", 34'(irq), 34'h1);
		wr(uec_pkg::IST_OFS, 32'h8, 2'h0);
		repeat (2) @(posedge clk);
		check("irq", 34'(irq), 34'h0);
		nak_mode <= 1'b0;
		// device role: setup end and receive ready service
		wr(uec_pkg::CFG_OFS, 32'h0, 2'h0);
		wr(uec_pkg::IMSK_OFS, 32'h3, 2'h0);
		pulse(3'h7);
		rd(uec_pkg::CSR_OFS, 32'h00110000, 32'h00110000, 2'h0);
		check("irq", 34'(irq), 34'h1);
		wr(uec_pkg::CSR_OFS, 32'h00800000, 2'h0);
		rd(uec_pkg::CSR_OFS, 32'h00910000, 32'h00010000, 2'h0);
		wr(uec_pkg::CSR_OFS, 32'h00400000, 2'h0);
		rd(uec_pkg::CSR_OFS, 32'h00410000, 32'h0, 2'h0);
		// flush while a receive packet is ready, one flush pulse
		pulse(3'h2);
		wr(uec_pkg::CSR_OFS, 32'hF1000000, 2'h0);
		rd(uec_pkg::CSR_OFS, 32'hF1010000, 32'h0, 2'h0);
		check("flush", 34'(n_flush), 34'h1);
		wr(uec_pkg::IST_OFS, 32'h1F, 2'h0);
		repeat (2) @(posedge clk);
		check("irq", 34'(irq), 34'h0);
		// unmapped and read-only places
		rd(8'h14, 32'hFFFFFFFF, 32'h0, 2'h2);
		wr(uec_pkg::STATE_OFS, 32'hFFFFFFFF, 2'h2);
		rd(uec_pkg::STATE_OFS, 32'hFFFFFFFC, uec_pkg::CAP_VALUE, 2'h0);
		repeat (3) @(posedge clk);
		print_verdict();
	end
endmodule
`default_nettype wire
